// [hdl/dee_ctrl.sv]
/*
 * data eeprom controller: key unlock, control register, address capture,
 * erase/program engine and the 256-word array, behind an axi4-lite slave.
 * assumes one 40 mhz clock, synchronous active-low reset, and reset event
 * pulses from the reset logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dee_map.svh"

// Contract
// - array of 256 words ends at 7fffffh
// - cpu never stalled during a cycle
// - only 55h then aah unlocks
// - start write accepted only within one window after unlock
// - key register reads back zero
// - software masks interrupts over unlock
// - start bit set-only, hardware clears at end
// - permit bit needed, cleared at end
// - abort flag set when reset cuts cycle
// - skip bit chooses pre-erase or not
// - erase select picks erase or write
// - decode one, four, eight word erase
// - 0100xx erases whole array
// - 001xxx programs one latched word
// - capture table write address internally
// - address held as 8+16 bit parts
// - address lsb forced to zero
// - upper address msb forced to zero
// - only low 16-bit data word carried
// - completion flag set at cycle end
module dee_ctrl
  import dee_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ext_reset_evt,   // pin reset pulse from reset logic
  input wire logic wdt_reset_evt,   // watchdog reset pulse
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic busy                 // erase or program cycle running
);

  // cycle length and unlock window, both in clock cycles
  localparam logic [15:0] OP_CYCLES = 16'(`DEE_OP_CYCLES);
  localparam logic [4:0] WIN_CYCLES = 5'(`DEE_UNLOCK_WIN_CYCLES);

  dee_state_t q;        // registered state
  dee_state_t next_q;   // next state
  logic wr_fire;        // a full register write is performed
  logic rd_fire;        // a read address is taken
  logic [15:0] ctrl_word;   // control register image
  logic addr_in_range;      // captured address hits the array
  logic [7:0] tgt_idx;      // word index of the captured address
  logic tbl_in_range;       // table pointer hits the array
  logic [7:0] tbl_idx;      // word index of the table pointer

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // handshake outputs straight from state
  assign s_axi_awready = !q.aw_have && !q.bvalid;
  assign s_axi_wready = !q.w_have && !q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign busy = (q.phase == PH_RUN);

  // a write fires once address and data are both held
  assign wr_fire = q.aw_have && q.w_have && !q.bvalid;
  assign rd_fire = s_axi_arvalid && !q.rvalid;

  // unimplemented bits 11..7 read as zero
  assign ctrl_word = {q.start_bit, q.op_permit_bit, q.aborted_op_flag, q.skip_preerase_bit,
                      5'h00, q.erase_sel, q.op_command_field};

  assign addr_in_range = (q.captured_addr_high == `DEE_PAGE_VALUE) &&
                         (q.captured_addr_low[15:9] == `DEE_LOW_TOP);
  assign tgt_idx = q.captured_addr_low[8:1];
  assign tbl_in_range = (q.table_page_reg == `DEE_PAGE_VALUE) &&
                        (q.table_offset[15:9] == `DEE_LOW_TOP);
  assign tbl_idx = q.table_offset[8:1];

  // next-state logic for bus, unlock, engine and array
  always_comb begin
    next_q = q;

    // write address and data channels, taken in either order
    if (s_axi_awvalid && !q.aw_have && !q.bvalid) begin
      next_q.aw_have = 1'b1;
      next_q.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_have && !q.bvalid) begin
      next_q.w_have = 1'b1;
      next_q.wdata = s_axi_wdata;
      next_q.wstrb = s_axi_wstrb;
    end
    // write response leaves on bready
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end

    // short window, masking left to software
    if (q.key == KEY_OPEN) begin
      if (q.win_cnt == 5'h00) begin
        next_q.key = KEY_LOCKED;
      end else begin
        next_q.win_cnt = q.win_cnt - 5'h01;
      end
    end

    // register write, performed once both halves are held
    if (wr_fire) begin
      next_q.aw_have = 1'b0;
      next_q.w_have = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = `DEE_RESP_OKAY;
      // any write consumes the unlock state
      if (q.key != KEY_LOCKED) begin
        next_q.key = KEY_LOCKED;
      end
      // decode the held write address
      case (q.awaddr)
        `DEE_CTRL_ADDR: begin
          // control fields frozen while a cycle runs
          if (q.phase == PH_IDLE) begin
            next_q.op_permit_bit = q.wstrb[1] ? q.wdata[`DEE_PERMIT_BIT] : q.op_permit_bit;
            next_q.skip_preerase_bit = q.wstrb[1] ? q.wdata[`DEE_SKIP_BIT] :
                                       q.skip_preerase_bit;
            next_q.erase_sel = q.wstrb[0] ? q.wdata[`DEE_ERASE_BIT] : q.erase_sel;
            next_q.op_command_field = q.wstrb[0] ? q.wdata[`DEE_OP_MSB:0] :
                                      q.op_command_field;
            // start accepted only in the window
            if (q.wstrb[1] && q.wdata[`DEE_START_BIT] && q.key == KEY_OPEN &&
                next_q.op_permit_bit) begin
              next_q.start_bit = 1'b1;
              next_q.phase = PH_RUN;
              next_q.timer = OP_CYCLES - 16'h0001;
            end
          end
        end
        `DEE_KEY_ADDR: begin
          if (q.wstrb[0] && q.wdata[7:0] == `DEE_KEY_FIRST) begin
            next_q.key = KEY_GOT_FIRST;
          end else if (q.wstrb[0] && q.wdata[7:0] == `DEE_KEY_SECOND &&
                       q.key == KEY_GOT_FIRST) begin
            next_q.key = KEY_OPEN;
            next_q.win_cnt = WIN_CYCLES - 5'h01;
          end
        end
        `DEE_PAGE_ADDR: begin
          next_q.table_page_reg = q.wstrb[0] ? q.wdata[7:0] : q.table_page_reg;
        end
        `DEE_OFFSET_ADDR: begin
          next_q.table_offset = merge16(q.table_offset, q.wdata, q.wstrb);
        end
        `DEE_TBLWT_ADDR: begin
          // table write captures the pointer, page msb and offset lsb cleared
          // kept as 8-bit high and 16-bit low
          next_q.captured_addr_high = {1'b0, q.table_page_reg[6:0]};
          next_q.captured_addr_low = {q.table_offset[15:1], 1'b0};
          next_q.write_latch = merge16(q.write_latch, q.wdata, q.wstrb);
        end
        `DEE_TBLRD_ADDR: begin
          // read-only port, write ignored
          next_q.bresp = `DEE_RESP_OKAY;
        end
        `DEE_STATUS_ADDR: begin
          // completion flag cleared by writing one
          if (q.wstrb[0] && q.wdata[`DEE_STATUS_DONE_BIT]) begin
            next_q.completion_irq_flag = 1'b0;
          end
        end
        default: begin
          // unmapped address
          next_q.bresp = `DEE_RESP_SLVERR;
        end
      endcase
    end

    // cycle engine: the array changes when the timer runs out
    if (q.phase == PH_RUN) begin
      if (q.timer != 16'h0000) begin
        next_q.timer = q.timer - 16'h0001;
      end else begin
        next_q.phase = PH_IDLE;
        next_q.start_bit = 1'b0;
        next_q.op_permit_bit = 1'b0;
        next_q.aborted_op_flag = 1'b0;
        // completion flag set, wins over clear
        next_q.completion_irq_flag = 1'b1;
        // every word decides on its own whether it changes
        for (int i = 0; i < `DEE_WORDS; i++) begin
          if (q.erase_sel) begin
            if (q.op_command_field[5:2] == `DEE_OP_BULK_TOP) begin
              next_q.mem[i] = `DEE_ERASED_WORD;
            end else if (addr_in_range) begin
              case (q.op_command_field)
                `DEE_OP_ERASE8: begin
                  if (8'(i) >> 3 == tgt_idx >> 3) begin
                    next_q.mem[i] = `DEE_ERASED_WORD;
                  end
                end
                `DEE_OP_ERASE4: begin
                  if (8'(i) >> 2 == tgt_idx >> 2) begin
                    next_q.mem[i] = `DEE_ERASED_WORD;
                  end
                end
                `DEE_OP_ERASE1: begin
                  if (8'(i) == tgt_idx) begin
                    next_q.mem[i] = `DEE_ERASED_WORD;
                  end
                end
                default: begin
                  next_q.mem[i] = q.mem[i];
                end
              endcase
            end
          end else if (q.op_command_field[5:3] == `DEE_OP_WRITE_TOP && addr_in_range &&
                       8'(i) == tgt_idx) begin
            next_q.mem[i] = q.skip_preerase_bit ? (q.mem[i] & q.write_latch) :
                            q.write_latch;
          end
        end
      end
    end

    // read channel: one cycle to answer
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_q.rvalid = 1'b1;
      next_q.rresp = `DEE_RESP_OKAY;
      next_q.rdata = 32'h0000_0000;
      // decode the read address as it is taken
      case (s_axi_araddr)
        `DEE_CTRL_ADDR: begin
          next_q.rdata = {16'h0000, ctrl_word};
        end
        `DEE_KEY_ADDR: begin
          next_q.rdata = 32'h0000_0000;
        end
        `DEE_PAGE_ADDR: begin
          next_q.rdata = {24'h00_0000, q.table_page_reg};
        end
        `DEE_OFFSET_ADDR: begin
          next_q.rdata = {16'h0000, q.table_offset};
        end
        `DEE_TBLWT_ADDR: begin
          next_q.rdata = {16'h0000, q.write_latch};
        end
        `DEE_TBLRD_ADDR: begin
          // array word; zero while busy or outside the array
          if (tbl_in_range && q.phase == PH_IDLE) begin
            next_q.rdata = {16'h0000, q.mem[tbl_idx]};
          end
        end
        `DEE_STATUS_ADDR: begin
          next_q.rdata = {30'h0000_0000, busy, q.completion_irq_flag};
        end
        default: begin
          next_q.rresp = `DEE_RESP_SLVERR;
        end
      endcase
    end

    // pin or watchdog reset: controller back to idle, array kept
    if (ext_reset_evt || wdt_reset_evt) begin
      next_q = '0;
      next_q.mem = q.mem;
      next_q.completion_irq_flag = q.completion_irq_flag;
      // abort flag when a cycle is cut off
      next_q.aborted_op_flag = (q.phase == PH_RUN) ? 1'b1 : q.aborted_op_flag;
    end

    // full reset: everything cleared, array erased
    if (!rst_n) begin
      next_q = '0;
      next_q.mem = '1;
    end
  end

  // single state register
  always_ff @(posedge mclk) begin
    q <= next_q;
  end

endmodule
`default_nettype wire

// [hdl/dee_map.svh]
/*
 * register offsets, field positions, reset values and timing counts of the
 * data eeprom controller.
 * assumes a 40 mhz system clock and a 32-bit axi4-lite register bus.
 */
`ifndef DEE_MAP_SVH
`define DEE_MAP_SVH

// register byte addresses
`define DEE_CTRL_ADDR 8'h00
`define DEE_KEY_ADDR 8'h04
`define DEE_PAGE_ADDR 8'h08
`define DEE_OFFSET_ADDR 8'h0c
`define DEE_TBLWT_ADDR 8'h10
`define DEE_TBLRD_ADDR 8'h14
`define DEE_STATUS_ADDR 8'h18

// control and status register fields
`define DEE_START_BIT 15
`define DEE_PERMIT_BIT 14
`define DEE_ABORT_BIT 13
`define DEE_SKIP_BIT 12
`define DEE_ERASE_BIT 6
`define DEE_OP_MSB 5
`define DEE_STATUS_DONE_BIT 0

// unlock keys
`define DEE_KEY_FIRST 8'h55
`define DEE_KEY_SECOND 8'haa

// operation codes
`define DEE_OP_ERASE8 6'h1a
`define DEE_OP_ERASE4 6'h19
`define DEE_OP_ERASE1 6'h18
`define DEE_OP_BULK_TOP 4'h4
`define DEE_OP_WRITE_TOP 3'h1

// array placement: 256 words ending at 7fffffh, upper page 7fh
`define DEE_WORDS 256
`define DEE_PAGE_VALUE 8'h7f
`define DEE_LOW_TOP 7'h7f
`define DEE_ERASED_WORD 16'hffff

// axi responses
`define DEE_RESP_OKAY 2'h0
`define DEE_RESP_SLVERR 2'h2

// timing
`define DEE_CLK_PERIOD_NS 25
`define DEE_OP_TIME_NS 2000
`define DEE_OP_CYCLES ((`DEE_OP_TIME_NS + `DEE_CLK_PERIOD_NS - 1) / `DEE_CLK_PERIOD_NS)
`define DEE_UNLOCK_WIN_CYCLES 16

`endif

// [hdl/dee_pkg.sv]
/*
 * types of the data eeprom controller: key and phase enums, full state record.
 * assumes dee_map.svh is on the include path.
 */
`include "dee_map.svh"

package dee_pkg;

  // unlock sequence progress
  typedef enum logic [1:0] {
    KEY_LOCKED,
    KEY_GOT_FIRST,
    KEY_OPEN
  } dee_key_t;

  // cycle engine phase
  typedef enum logic {
    PH_IDLE,
    PH_RUN
  } dee_phase_t;

  // the whole state of the controller
  typedef struct packed {
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic start_bit;
    logic op_permit_bit;
    logic aborted_op_flag;
    logic skip_preerase_bit;
    logic erase_sel;
    logic [5:0] op_command_field;
    logic completion_irq_flag;
    dee_key_t key;
    logic [4:0] win_cnt;
    dee_phase_t phase;
    logic [15:0] timer;
    logic [7:0] table_page_reg;
    logic [15:0] table_offset;
    logic [15:0] write_latch;
    logic [7:0] captured_addr_high;
    logic [15:0] captured_addr_low;
    logic [`DEE_WORDS-1:0][15:0] mem;
  } dee_state_t;

endpackage

// [verification/dee_ctrl_chk.sv]
/* port assertions for the data eeprom controller.
   assumes it is bound onto dee_ctrl, one clock mclk. */
`timescale 1ns/10ps
`default_nettype none
`include "dee_map.svh"
module dee_ctrl_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ext_reset_evt,
  input wire logic wdt_reset_evt,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic busy
);
  logic [7:0] run_cnt; // edges seen busy
  logic ar_go; // read request taken
  logic evt; // any reset event
  assign ar_go = s_axi_arvalid && s_axi_arready;
  assign evt = ext_reset_evt || wdt_reset_evt;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // count the length of a cycle
  always_ff @(posedge mclk) begin
    if (!rst_n || !busy) begin
      run_cnt <= 8'h00;
    end else begin
      run_cnt <= run_cnt + 8'h01;
    end
  end
  a_run_length: assert property ($fell(busy) && $past(rst_n) && !$past(evt)
    |-> run_cnt == `DEE_OP_CYCLES) else $error("cycle length wrong");
  a_abort_stop: assert property (busy && evt |=> !busy)
    else $error("cycle not cut by reset event");
  a_start_src: assert property ($rose(busy) |-> $rose(s_axi_bvalid))
    else $error("cycle began without a write");
  a_read_lat: assert property (ar_go |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready && !evt |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_key_blind: assert property (ar_go && s_axi_araddr == `DEE_KEY_ADDR |=>
    s_axi_rdata == 32'h0) else $error("key register readable");
  a_ctrl_rsv: assert property (ar_go && s_axi_araddr == `DEE_CTRL_ADDR |=>
    (s_axi_rdata & 32'hffff0f80) == 32'h0) else $error("unused control bits set");
  a_bad_addr: assert property (ar_go && s_axi_araddr > `DEE_STATUS_ADDR |=>
    s_axi_rresp == `DEE_RESP_SLVERR) else $error("unmapped read not refused");
endmodule
bind dee_ctrl dee_ctrl_chk chk (.mclk, .rst_n, .ext_reset_evt, .wdt_reset_evt,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .busy);
`default_nettype wire

// [verification/dee_cpu_model.sv]
/* cpu side model: axi4-lite master doing register accesses.
   assumes calls come one at a time from the bench on mclk. */
`timescale 1ns/10ps
`default_nettype none
`include "dee_map.svh"
module dee_cpu_model (
  input wire logic mclk,
  output var logic [7:0] s_axi_awaddr,
  output var logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output var logic [31:0] s_axi_wdata,
  output var logic [3:0] s_axi_wstrb,
  output var logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output var logic s_axi_bready,
  output var logic [7:0] s_axi_araddr,
  output var logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output var logic s_axi_rready
);
  logic hung = 1'b0; // a wait ran out
  // idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, s_axi_wstrb} = '0;
  end
  // one write; each channel dropped and scrambled once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    n = 0;
    do begin
      @(posedge mclk);
      if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      n++;
    end while (!s_axi_bvalid && n < 200);
    s_axi_bready <= 1'b0;
    if (!s_axi_bvalid) hung = 1'b1;
  endtask
  // one read; the bench watches the answer
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge mclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    n = 0;
    do begin
      @(posedge mclk);
      if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
      n++;
    end while (!s_axi_rvalid && n < 200);
    s_axi_rready <= 1'b0;
    if (!s_axi_rvalid) hung = 1'b1;
  endtask
  // setup, keys, start back to back
  task automatic st(input logic [15:0] c);
    wr(`DEE_CTRL_ADDR, {16'h0, c});
    wr(`DEE_KEY_ADDR, 32'h55);
    wr(`DEE_KEY_ADDR, 32'haa);
    wr(`DEE_CTRL_ADDR, {16'h0, c | 16'h8000});
  endtask
endmodule
`default_nettype wire

// [verification/data_eeprom_controller_test.sv]
/* self-checking bench for the data eeprom controller.
   assumes dee_ctrl, dee_cpu_model and the checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "dee_map.svh"
module data_eeprom_controller_test;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ext_reset_evt = 1'b0;
  logic wdt_reset_evt = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, busy;
  int fail_count = 0;
  int num_checks = 0;
  logic [33:0] exp_q[$]; // expected read answers, oldest first
  logic [1:0] exp_bq[$]; // expected write responses, oldest first
  logic [15:0] d[8]; // words programmed
  always #12.5 mclk = ~mclk;
  dee_ctrl dut (.mclk, .rst_n, .ext_reset_evt, .wdt_reset_evt, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .busy);
  dee_cpu_model cpu (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready);
  task automatic test_done();
    // let the watcher take the last answer first
    repeat (2) @(posedge mclk);
    // a note never matched is a lost answer
    if (exp_q.size() != 0 || exp_bq.size() != 0) begin
      fail_count++;
    end
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // stop on a hung bus or cycle
  task automatic guard(input logic bad);
    if (bad !== 1'b0) begin
      fail_count++;
      test_done();
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] v);
    exp_bq.push_back(`DEE_RESP_OKAY);
    cpu.wr(a, v);
    guard(cpu.hung);
  endtask
  // note the answer, then read
  task automatic r(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    cpu.rd(a);
    guard(cpu.hung);
  endtask
  // capture an address through a table write
  task automatic cap(input logic [7:0] p, input logic [15:0] o, input logic [15:0] v);
    w(`DEE_PAGE_ADDR, {24'h0, p});
    w(`DEE_OFFSET_ADDR, {16'h0, o});
    w(`DEE_TBLWT_ADDR, {16'hdead, v});
  endtask
  task automatic rt(input logic [15:0] o, input logic [33:0] e);
    w(`DEE_OFFSET_ADDR, {16'h0, o});
    r(`DEE_TBLRD_ADDR, e);
  endtask
  task automatic go(input logic [15:0] c);
    int n;
    cpu.st(c);
    guard(cpu.hung);
    n = 0;
    // no array read until the cycle ends
    while (busy && n < 200) begin
      @(posedge mclk);
      n++;
    end
    guard(busy);
  endtask
  // compare each read answer with the oldest note
  always @(posedge mclk) begin
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
      chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
    // compare each write response with the oldest note
    if (s_axi_bvalid && s_axi_bready && exp_bq.size() > 0) begin
      chk({32'h0, s_axi_bresp}, {32'h0, exp_bq.pop_front()});
    end
  end
  initial begin
    int i;
    void'($urandom(32'h174b));
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    r(`DEE_CTRL_ADDR, 34'h0);
    w(`DEE_KEY_ADDR, 32'h55);
    r(`DEE_KEY_ADDR, 34'h0);
    r(8'h1c, {`DEE_RESP_SLVERR, 32'h0});
    // an unmapped write is refused
    exp_bq.push_back(`DEE_RESP_SLVERR);
    cpu.wr(8'h1c, 32'h0);
    guard(cpu.hung);
    w(`DEE_PAGE_ADDR, 32'h7f);
    rt(16'hfe00, 34'hffff);
    // eight words via a high page, odd offsets, every write code
    for (i = 0; i < 8; i++) begin
      d[i] = 16'($urandom);
      cap(8'hff, 16'hfe01 + 16'(2 * i), d[i]);
      go(16'h4008 | 16'(i));
    end
    w(`DEE_PAGE_ADDR, 32'h7f);
    for (i = 0; i < 8; i++) begin
      rt(16'hfe00 + 16'(2 * i), {18'h0, d[i]});
    end
    // program-only ands into the old word
    cap(8'h7f, 16'hfe00, 16'h00ff);
    go(16'h5008);
    rt(16'hfe00, {18'h0, d[0] & 16'h00ff});
    w(`DEE_TBLWT_ADDR, 32'h1200);
    w(`DEE_STATUS_ADDR, 32'h1);
    cpu.st(16'h4008);
    r(`DEE_STATUS_ADDR, 34'h2);
    w(`DEE_CTRL_ADDR, 32'h0);
    r(`DEE_CTRL_ADDR, 34'hc008);
    go(16'h4008);
    r(`DEE_STATUS_ADDR, 34'h1);
    r(`DEE_CTRL_ADDR, 34'h8);
    r(`DEE_TBLRD_ADDR, 34'h1200);
    // erase one, four, then eight words
    cap(8'h7f, 16'hfe0e, 16'h0);
    go(16'h4058);
    cap(8'h7f, 16'hfe00, 16'h0);
    go(16'h4059);
    for (i = 0; i < 8; i++) begin
      rt(16'hfe00 + 16'(2 * i), {18'h0, (i < 4 || i == 7) ? 16'hffff : d[i]});
    end
    cap(8'h7f, 16'hfe08, 16'h0);
    go(16'h405a);
    rt(16'hfe0a, 34'hffff);
    // program-only write into a word erased just before
    cap(8'h7f, 16'hfe02, 16'h3c3c);
    go(16'h5008);
    rt(16'hfe02, 34'h3c3c);
    cap(8'h7f, 16'hff90, 16'h5a5a);
    go(16'h4008);
    cap(8'h7f, 16'h0000, 16'h0);
    go(16'h4052);
    rt(16'hff90, 34'hffff);
    // broken unlocks: reversed, interrupted, late, no permit
    for (i = 0; i < 4; i++) begin
      w(`DEE_CTRL_ADDR, i == 3 ? 32'h58 : 32'h4058);
      w(`DEE_KEY_ADDR, i == 0 ? 32'haa : 32'h55);
      if (i == 1) w(`DEE_PAGE_ADDR, 32'h7f);
      w(`DEE_KEY_ADDR, i == 0 ? 32'h55 : 32'haa);
      if (i == 2) repeat (20) @(posedge mclk);
      w(`DEE_CTRL_ADDR, i == 3 ? 32'h8058 : 32'hc058);
      chk({33'h0, busy}, 34'h0);
      r(`DEE_CTRL_ADDR, i == 3 ? 34'h58 : 34'h4058);
    end
    // pin then watchdog reset cut a running cycle
    for (i = 0; i < 2; i++) begin
      cpu.st(16'h4008);
      repeat (10) @(posedge mclk);
      {wdt_reset_evt, ext_reset_evt} <= 2'(i + 1);
      @(posedge mclk);
      {wdt_reset_evt, ext_reset_evt} <= 2'h0;
      r(`DEE_CTRL_ADDR, 34'h2000);
      // a clean cycle clears the flag before the next cut
      go(16'h4008);
      r(`DEE_CTRL_ADDR, 34'h8);
    end
    test_done();
  end
endmodule
`default_nettype wire
